// File: rtl/sync_serial_map.svh
`ifndef SYNC_SERIAL_MAP_SVH
`define SYNC_SERIAL_MAP_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DATA 8'h04
`define OFS_BAUD 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_CLR 8'h10
`define OFS_IRQ_EN 8'h14
// Control register bit positions
`define B_PORT_EN 0
`define B_SYNC 1
`define B_CLK_MASTER 2
`define B_SINGLE_RX 3
`define B_CONT_RX 4
`define B_NINE_BIT 5
`define B_CHAR_IE 6
`define B_OVERRUN 8
`define B_NINTH 9
`define B_CHAR_FLAG 10
// Event bits of the interrupt registers
`define EV_CHAR 0
`define EV_OVR 1
// Reset values and timing counts
`define BAUD_RST 16'h0007
`define PART_HALF 16'h0007
`define CHAR_BITS_8 4'h8
`define CHAR_BITS_9 4'h9
`endif

// File: rtl/sync_serial_pkg.sv
`include "sync_serial_map.svh"
`default_nettype none
package sync_serial_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RUN = 2'b01
  } phase_t;

  function automatic logic [3:0] char_bits(input logic nine);
    char_bits = nine ? `CHAR_BITS_9 : `CHAR_BITS_8;
  endfunction

  typedef struct packed {
    logic [2:0] ck_sync;
    logic [2:0] dt_sync;
    logic ck_lvl;
    logic port_en;
    logic sync;
    logic clk_master;
    logic single_rx;
    logic cont_rx;
    logic nine_bit;
    logic char_ie;
    logic [15:0] baud;
    logic overrun;
    logic overrun_cont;
    logic [1:0][8:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    phase_t phase;
    logic [8:0] shift;
    logic [3:0] bit_cnt;
    logic [15:0] div_cnt;
    logic ck_o;
    logic ck_oe;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } rx_state_t;

  typedef struct packed {
    logic [2:0] ck_sync;
    logic ck_lvl;
    phase_t phase;
    logic master;
    logic [8:0] data;
    logic [3:0] nbits;
    logic [3:0] idx;
    logic [15:0] div_cnt;
    logic ck_o;
    logic ck_oe;
    logic dt_o;
    logic dt_oe;
    logic done;
  } part_state_t;

endpackage
`default_nettype wire

// File: rtl/sync_link_if.sv
`default_nettype none
interface sync_link_if;
  logic dev_ck_o;
  logic dev_ck_oe;
  logic dev_dt_o;
  logic dev_dt_oe;
  logic part_ck_o;
  logic part_ck_oe;
  logic part_dt_o;
  logic part_dt_oe;
  logic ck;
  logic dt;

  // Released lines are pulled low
  assign ck = dev_ck_oe ? dev_ck_o : (part_ck_oe ? part_ck_o : 1'b0);
  assign dt = dev_dt_oe ? dev_dt_o : (part_dt_oe ? part_dt_o : 1'b0);

  modport dev (
    input ck,
    input dt,
    output dev_ck_o,
    output dev_ck_oe,
    output dev_dt_o,
    output dev_dt_oe
  );

  modport part (
    input ck,
    input dt,
    output part_ck_o,
    output part_ck_oe,
    output part_dt_o,
    output part_dt_oe
  );
endinterface
`default_nettype wire

// File: rtl/sync_serial_partner.sv
`include "sync_serial_map.svh"
`default_nettype none
module sync_serial_partner
  import sync_serial_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic as_master,
  input wire logic nine_bit,
  input wire logic [8:0] tx_data,
  output logic busy,
  output logic done,
  sync_link_if.part link
);

  part_state_t state_reg;
  part_state_t state_next;

  always_comb begin
    logic rise;
    logic fall;
    logic tick;
    rise = 1'b0;
    fall = 1'b0;
    tick = 1'b0;
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.ck_sync = {state_reg.ck_sync[1:0], link.ck};
    if (state_reg.ck_sync[2] == state_reg.ck_sync[1]) begin
      state_next.ck_lvl = state_reg.ck_sync[1];
    end
    case (state_reg.phase)
      PH_IDLE: begin
        if (start) begin
          state_next.phase = PH_RUN;
          state_next.master = as_master;
          state_next.data = tx_data;
          state_next.nbits = char_bits(nine_bit);
          state_next.idx = 4'h0;
          state_next.div_cnt = 16'h0000;
          state_next.dt_o = tx_data[0];
          state_next.dt_oe = 1'b1;
          state_next.ck_oe = as_master;
        end
      end
      PH_RUN: begin
        if (state_reg.master) begin
          tick = state_reg.div_cnt == `PART_HALF;
          state_next.div_cnt = tick ? 16'h0000 : state_reg.div_cnt + 16'h0001;
          if (tick) begin
            state_next.ck_o = ~state_reg.ck_o;
            rise = ~state_reg.ck_o;
            fall = state_reg.ck_o;
          end
        end else begin
          rise = ~state_reg.ck_lvl & (state_reg.ck_sync[2:1] == 2'b11);
          fall = state_reg.ck_lvl & (state_reg.ck_sync[2:1] == 2'b00);
        end
        if (rise) begin
          state_next.dt_o = state_reg.data[state_reg.idx]; // RL10
        end
        if (fall) begin
          if (state_reg.idx == state_reg.nbits - 4'h1) begin
            // Stop after exactly one clock per data bit
            state_next.phase = PH_IDLE; // RL11
            state_next.dt_oe = 1'b0;
            state_next.ck_oe = 1'b0;
            state_next.done = 1'b1;
          end else begin
            state_next.idx = state_reg.idx + 4'h1; // RL10
          end
        end
      end
      default: begin
        state_next.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.phase == PH_RUN;
  assign done = state_reg.done;
  assign link.part_ck_o = state_reg.ck_o;
  assign link.part_ck_oe = state_reg.ck_oe;
  assign link.part_dt_o = state_reg.dt_o;
  assign link.part_dt_oe = state_reg.dt_oe;

endmodule
`default_nettype wire

// File: rtl/sync_serial_receiver.sv
`include "sync_serial_map.svh"
`default_nettype none
// Overview of operation
// [RL1] Data pin driver off in master receive
// [RL2] Reception starts on single or continuous enable
// [RL3] Single mode: one character, then enable clears
// [RL4] Continuous clocks; clearing mid-character discards it
// [RL5] Both set: single clears, continuous continues
// [RL6] Sample data on trailing clock edge
// [RL7] Full character sets flag, enters FIFO
// [RL8] Oldest character shown; flag while unread
// [RL9] Slave takes clock pin, driver off
// [RL10] Data changes leading edge, one bit/cycle
// [RL11] External master sends only character's bits
// [RL12] Third character: overrun, keep FIFO, stop
// [RL13] Overrun clears by read or enables
// [RL14] Nine-bit mode, ninth bit exposed
// [RL15] Software reads ninth bit before data
// [RL16] Software configures before enabling reception
// [RL17] Interrupt on flag with enable set
// [RL18] Disabled sections release their pins
// [RL19] Data read pops the oldest character
module sync_serial_receiver
  import sync_serial_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic irq,
  sync_link_if.dev link
);

  rx_state_t state_reg;
  rx_state_t state_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic access;
    logic wr;
    logic rd;
    logic pop;
    logic run_ok;
    logic tick;
    logic sample;
    logic done;
    logic wi;
    logic [8:0] word;
    logic [1:0] ev;
    access = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    wr = access & wb_we_i;
    rd = access & ~wb_we_i;
    pop = rd & (wb_adr_i == `OFS_DATA) & (state_reg.count != 2'h0);
    tick = 1'b0;
    sample = 1'b0;
    done = 1'b0;
    ev = 2'h0;
    wi = state_reg.rd_ptr ^ state_reg.count[0];
    word = state_reg.shift;
    state_next = state_reg;
    state_next.ack = access;
    state_next.ck_sync = {state_reg.ck_sync[1:0], link.ck};
    state_next.dt_sync = {state_reg.dt_sync[1:0], link.dt};
    if (state_reg.ck_sync[2] == state_reg.ck_sync[1]) begin
      state_next.ck_lvl = state_reg.ck_sync[1];
    end
    run_ok = state_reg.port_en & state_reg.sync & ~state_reg.overrun // RL12
      & (state_reg.single_rx | state_reg.cont_rx); // RL2

    // Serial engine
    case (state_reg.phase)
      PH_IDLE: begin
        if (run_ok) begin
          state_next.phase = PH_RUN; // RL2
        end
      end
      PH_RUN: begin
        if (!run_ok) begin
          // Clock stops at once, partial character dropped
          state_next.phase = PH_IDLE; // RL4
          state_next.bit_cnt = 4'h0; // RL4
          state_next.div_cnt = 16'h0000;
          state_next.ck_o = 1'b0; // RL4
        end else if (state_reg.clk_master) begin
          tick = state_reg.div_cnt == state_reg.baud;
          state_next.div_cnt = tick ? 16'h0000
            : state_reg.div_cnt + 16'h0001;
          if (tick) begin
            state_next.ck_o = ~state_reg.ck_o; // RL4
            sample = state_reg.ck_o; // RL6
          end
        end else begin
          sample = state_reg.ck_lvl
            & (state_reg.ck_sync[2:1] == 2'b00); // RL6
        end
      end
      default: begin
        state_next.phase = PH_IDLE;
      end
    endcase

    if (sample) begin
      word[state_reg.bit_cnt] = state_reg.dt_sync[2]; // RL6
      if (!state_reg.nine_bit) begin
        word[8] = 1'b0;
      end
      state_next.shift = word;
      if (state_reg.bit_cnt == char_bits(state_reg.nine_bit) - 4'h1) begin
        done = 1'b1; // RL14
        state_next.bit_cnt = 4'h0;
      end else begin
        state_next.bit_cnt = state_reg.bit_cnt + 4'h1; // RL10
      end
    end

    // Receive FIFO
    if (pop) begin
      state_next.rd_ptr = ~state_reg.rd_ptr; // RL19
    end
    if (done) begin
      state_next.single_rx = 1'b0; // RL3 RL5
      if (state_reg.count == 2'h2) begin
        // FIFO untouched, engine halts on the flag
        state_next.overrun = 1'b1; // RL12
        state_next.overrun_cont = state_reg.cont_rx;
        ev[`EV_OVR] = 1'b1;
      end else begin
        state_next.fifo[wi] = word; // RL7
        ev[`EV_CHAR] = 1'b1;
      end
    end
    state_next.count = state_reg.count + {1'b0, ev[`EV_CHAR]}
      - {1'b0, pop}; // RL7 RL19

    // Register writes
    if (wr) begin
      case (wb_adr_i)
        `OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            state_next.port_en = wb_dat_i[`B_PORT_EN];
            state_next.sync = wb_dat_i[`B_SYNC];
            state_next.clk_master = wb_dat_i[`B_CLK_MASTER];
            state_next.single_rx = wb_dat_i[`B_SINGLE_RX];
            state_next.cont_rx = wb_dat_i[`B_CONT_RX];
            state_next.nine_bit = wb_dat_i[`B_NINE_BIT];
            state_next.char_ie = wb_dat_i[`B_CHAR_IE];
          end
        end
        `OFS_BAUD: begin
          if (wb_sel_i[0]) begin
            state_next.baud[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            state_next.baud[15:8] = wb_dat_i[15:8];
          end
        end
        `OFS_IRQ_CLR: begin
          if (wb_sel_i[0]) begin
            state_next.irq_stat = state_reg.irq_stat & ~wb_dat_i[1:0];
          end
        end
        `OFS_IRQ_EN: begin
          if (wb_sel_i[0]) begin
            state_next.irq_en = wb_dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // New events win over a clear in the same cycle
    state_next.irq_stat = state_next.irq_stat | ev;

    // Overrun release
    if (state_reg.overrun & ~done) begin
      if (!state_reg.overrun_cont && pop) begin
        state_next.overrun = 1'b0; // RL13
      end
      if (state_reg.overrun_cont && !state_next.cont_rx) begin
        state_next.overrun = 1'b0; // RL13
      end
    end

    // Port enable low acts as a local reset
    if (!state_next.port_en) begin
      state_next.overrun = 1'b0; // RL13
      state_next.count = 2'h0;
      state_next.rd_ptr = 1'b0;
      state_next.phase = PH_IDLE;
      state_next.bit_cnt = 4'h0;
      state_next.div_cnt = 16'h0000;
      state_next.ck_o = 1'b0;
    end

    // Clock driver only for an enabled synchronous master
    state_next.ck_oe = state_next.port_en & state_next.sync
      & state_next.clk_master; // RL9 RL18

    // Register reads
    state_next.dat = 32'h0000_0000;
    if (rd) begin
      case (wb_adr_i)
        `OFS_CTRL: begin
          state_next.dat[`B_PORT_EN] = state_reg.port_en;
          state_next.dat[`B_SYNC] = state_reg.sync;
          state_next.dat[`B_CLK_MASTER] = state_reg.clk_master;
          state_next.dat[`B_SINGLE_RX] = state_reg.single_rx;
          state_next.dat[`B_CONT_RX] = state_reg.cont_rx;
          state_next.dat[`B_NINE_BIT] = state_reg.nine_bit;
          state_next.dat[`B_CHAR_IE] = state_reg.char_ie;
          state_next.dat[`B_OVERRUN] = state_reg.overrun;
          // Ninth bit only of an unread character
          state_next.dat[`B_NINTH] = (state_reg.count != 2'h0)
            & state_reg.fifo[state_reg.rd_ptr][8]; // RL14 RL15
          state_next.dat[`B_CHAR_FLAG] = state_reg.count != 2'h0; // RL8
        end
        `OFS_DATA: begin
          state_next.dat[7:0] = state_reg.fifo[state_reg.rd_ptr][7:0]; // RL8
        end
        `OFS_BAUD: begin
          state_next.dat[15:0] = state_reg.baud;
        end
        `OFS_IRQ_STAT: begin
          state_next.dat[1:0] = state_reg.irq_stat;
        end
        `OFS_IRQ_EN: begin
          state_next.dat[1:0] = state_reg.irq_en;
        end
        default: begin
        end
      endcase
    end

    state_next.irq = |(state_next.irq_stat & state_next.irq_en)
      | ((state_next.count != 2'h0) & state_next.char_ie); // RL17
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= '0;
      state_reg.baud <= `BAUD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.dat;
  assign irq = state_reg.irq;
  assign link.dev_ck_o = state_reg.ck_o;
  assign link.dev_ck_oe = state_reg.ck_oe;
  // Receive-only end: the data driver stays off
  assign link.dev_dt_o = 1'b0; // RL1
  assign link.dev_dt_oe = 1'b0; // RL1 RL18

endmodule
`default_nettype wire

// File: verification/sync_link_monitor.sv
`default_nettype none
module sync_link_monitor #(
  parameter int HALF = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic dev_ck_o,
  input wire logic dev_ck_oe,
  input wire logic dev_dt_oe,
  input wire logic part_ck_o,
  input wire logic part_ck_oe,
  input wire logic part_dt_o,
  input wire logic part_dt_oe,
  input wire logic ck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low_cnt;
  logic [3:0] fall_cnt;

  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////
  // Low time of the device clock, falls per partner frame
  always_ff @(posedge clock) begin
    if (!rst_b || dev_ck_o) begin
      low_cnt <= 5'h0;
    end else if (low_cnt != 5'h1f) begin
      low_cnt <= low_cnt + 5'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || !part_dt_oe) begin
      fall_cnt <= 4'h0;
    end else if ($fell(ck)) begin
      fall_cnt <= fall_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  chk_dt_released:
    assert property (!dev_dt_oe) else $error("device drove data line");
  chk_one_driver:
    assert property (!(dev_ck_oe && part_ck_oe))
      else $error("both ends drive clock");
  chk_dt_steady_fall:
    assert property ($fell(ck) && part_dt_oe |-> $stable(part_dt_o))
      else $error("data moved at trailing edge");
  chk_dt_moves_high:
    assert property (part_dt_oe && $past(part_dt_oe) && $changed(part_dt_o)
      |-> ck) else $error("data changed while clock low");
  chk_ck_low_time:
    assert property ($rose(dev_ck_o) |-> low_cnt >= 5'(HALF))
      else $error("device clock low phase short");
  chk_part_ck_half:
    assert property ($rose(part_ck_o) |-> part_ck_o [*8] ##1 !part_ck_o)
      else $error("partner clock high phase wrong");
  chk_bits_frame:
    assert property ($fell(part_dt_oe)
      |-> (fall_cnt + 4'($fell(ck))) inside {4'h8, 4'h9})
      else $error("wrong clock count in frame");
  chk_reset_quiet:
    assert property (disable iff (1'b0) !rst_b |=> !dev_ck_oe && !part_dt_oe)
      else $error("pins driven in reset");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`include "sync_serial_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic ack;
  logic [31:0] rdat;
  logic irq;
  logic start = 1'b0;
  logic as_master = 1'b0;
  logic nine_bit = 1'b0;
  logic [8:0] tx_data = 9'h0;
  logic busy;
  logic done;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] exp_q[$];
  logic [8:0] d[3];

  sync_link_if link();
  sync_serial_receiver sync_serial_receiver_i(.clock(clock), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .irq(irq), .link(link));
  sync_serial_partner sync_serial_partner_i(.clock(clock), .rst_b(rst_b),
    .start(start), .as_master(as_master), .nine_bit(nine_bit),
    .tx_data(tx_data), .busy(busy), .done(done), .link(link));
  sync_link_monitor #(.HALF(8)) sync_link_monitor_i(.clock(clock),
    .rst_b(rst_b), .dev_ck_o(link.dev_ck_o), .dev_ck_oe(link.dev_ck_oe),
    .dev_dt_oe(link.dev_dt_oe), .part_ck_o(link.part_ck_o),
    .part_ck_oe(link.part_ck_oe), .part_dt_o(link.part_dt_o),
    .part_dt_oe(link.part_dt_oe), .ck(link.ck));

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout;
    err_count++;
    tally_and_finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i;
    i = 0;
    @(posedge clock);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clock);
      i++;
      if (i > 20) timeout();
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic send(input logic m, input logic n9, input logic [8:0] v);
    @(posedge clock);
    as_master <= m;
    nine_bit <= n9;
    tx_data <= v;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask

  task automatic wait_done;
    int i;
    i = 0;
    while (done !== 1'b1) begin
      @(posedge clock);
      i++;
      if (i > 3000) timeout();
    end
    check(busy, 1'b0);
  endtask

  task automatic wait_rises(input int n);
    int i;
    logic prev;
    i = 0;
    prev = link.ck;
    while (n > 0) begin
      @(posedge clock);
      if (link.ck === 1'b1 && prev === 1'b0) n--;
      prev = link.ck;
      i++;
      if (i > 500) timeout();
    end
  endtask

  task automatic ck_quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      check(link.ck, 1'b0);
    end
  endtask

  // Read results in issue order
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check(rdat, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hb532));
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_BAUD, 32'h7);
    wb(1'b1, 8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0);
    wb(1'b1, `OFS_IRQ_EN, 32'h3);
    wb(1'b1, `OFS_CTRL, 32'h7);
    d[0] = 9'($urandom);
    send(1'b0, 1'b0, d[0]);
    wb(1'b1, `OFS_CTRL, 32'hf);
    wait_done;
    repeat (4) @(posedge clock);
    check(irq, 1'b1);
    rd(`OFS_CTRL, 32'h407);
    rd(`OFS_IRQ_STAT, 32'h1);
    rd(`OFS_DATA, {24'h0, d[0][7:0]});
    rd(`OFS_CTRL, 32'h7);
    wb(1'b1, `OFS_IRQ_CLR, 32'h3);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    // Three nine-bit characters, third overruns
    wb(1'b1, `OFS_CTRL, 32'h27);
    for (int k = 0; k < 3; k++) begin
      d[k] = 9'($urandom);
      send(1'b0, 1'b1, d[k]);
      wb(1'b1, `OFS_CTRL, 32'h2f);
      wait_done;
    end
    repeat (2) @(posedge clock);
    wb(1'b1, `OFS_CTRL, 32'h2f);
    ck_quiet(30);
    wb(1'b1, `OFS_CTRL, 32'h27);
    rd(`OFS_CTRL, {22'h1, d[0][8], 1'b1, 8'h27});
    rd(`OFS_IRQ_STAT, 32'h3);
    rd(`OFS_DATA, {24'h0, d[0][7:0]});
    rd(`OFS_CTRL, {22'h1, d[1][8], 1'b0, 8'h27});
    rd(`OFS_DATA, {24'h0, d[1][7:0]});
    rd(`OFS_CTRL, 32'h27);
    // Slave device, partner makes the clock
    wb(1'b1, `OFS_IRQ_CLR, 32'h3);
    wb(1'b1, `OFS_CTRL, 32'h13);
    d[2] = 9'($urandom);
    send(1'b1, 1'b0, d[2]);
    wait_done;
    repeat (6) @(posedge clock);
    rd(`OFS_DATA, {24'h0, d[2][7:0]});
    // Both enables, then continuous cancelled mid-character
    wb(1'b1, `OFS_CTRL, 32'h7);
    d[0] = 9'($urandom);
    send(1'b0, 1'b0, d[0]);
    wb(1'b1, `OFS_CTRL, 32'h1f);
    wait_done;
    wait_rises(3);
    rd(`OFS_CTRL, 32'h417);
    wb(1'b1, `OFS_CTRL, 32'h7);
    ck_quiet(20);
    rd(`OFS_DATA, {24'h0, d[0][7:0]});
    rd(`OFS_CTRL, 32'h7);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(`OFS_CTRL, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
